// ==== inc/fls_consts.vh ====
// Constants for the flash lock and status command sequencer
//
// Contract
// - 77h then D0h at a block's top even address clears that block's lock bit.
// - Ready flag is low while lock-set runs, high when it finishes.
// - 71h then D0h at a block address captures its lock state into query result.
// - One lock bit per block; 0 blocks program and erase, 1 permits both.
// - A lock bit returns to one only by erasing its block.
// - Lock-disable high treats all blocks unlocked; stored lock bits stay untouched.
// - With lock-disable high, erases ignore lock bits; erased blocks then read one.
// - Ready is 0 during program, erase, erase-all, lock-set, lock-query; reset value 1.
// - Status byte: bit 7 ready, bit 5 erase fail, bit 4 program fail.
// - In RAM rewrite mode reads return status after an operation until read-array.
// - Both failure flags reset to 0 and clear on clear-status.
// - Program, erase, erase-all, lock-set ignored while any failure flag is set.
// - Second cycle not D0h or FFh for lock-set or erases sets both flags.
// - FFh as second cycle cancels the command and enters array-read mode; program takes FFh as data instead.
// - Erase fail alone for erase of locked block or failed erase verify.
// - Program fail alone for locked program, failed program, failed lock-set.
// - With lock-disable high, no error for operations on locked blocks.
// - Commands are 16-bit writes; the upper byte of the code is ignored.
// - Code 50h clears both failure flags and their mirrors to 00b.
// - After 70h the next read returns the status byte.
`ifndef FLS_CONSTS_VH
`define FLS_CONSTS_VH

`define FLS_CMD_READ_ARRAY 8'hff
`define FLS_CMD_READ_STATUS 8'h70
`define FLS_CMD_CLEAR_STATUS 8'h50
`define FLS_CMD_PROGRAM 8'h40
`define FLS_CMD_ERASE 8'h20
`define FLS_CMD_ERASE_ALL 8'ha7
`define FLS_CMD_LOCK_SET 8'h77
`define FLS_CMD_LOCK_QUERY 8'h71
`define FLS_CMD_CONFIRM 8'hd0

`define FLS_ST_READY 7
`define FLS_ST_ERASE_FAIL 5
`define FLS_ST_PROGRAM_FAIL 4

`define FLS_NUM_BLK 16
`define FLS_BLK_MSB 15
`define FLS_BLK_LSB 12
`define FLS_BLK_A 15
`define FLS_ADDR_W 20

`define FLS_OP_PROGRAM 2'h0
`define FLS_OP_ERASE 2'h1
`define FLS_OP_ERASE_ALL 2'h2
`define FLS_OP_LOCK_SET 2'h3

`define FLS_LOCK_RESET 16'hffff
`define FLS_READY_RESET 1'b1
`define FLS_FAIL_RESET 1'b0

`endif

// ==== src/fls_cmd_decode.v ====
// Command code classifier for the low byte of a command write
`timescale 1ns/10ps
`include "fls_consts.vh"
module fls_cmd_decode (
  input wire [15:0] i_word,
  output wire o_read_array,
  output wire o_read_status,
  output wire o_clear_status,
  output wire o_program,
  output wire o_erase,
  output wire o_erase_all,
  output wire o_lock_set,
  output wire o_lock_query,
  output wire o_confirm
);
  wire [7:0] code;

  assign code = i_word[7:0];
  assign o_read_array = (code == `FLS_CMD_READ_ARRAY);
  assign o_read_status = (code == `FLS_CMD_READ_STATUS);
  assign o_clear_status = (code == `FLS_CMD_CLEAR_STATUS);
  assign o_program = (code == `FLS_CMD_PROGRAM);
  assign o_erase = (code == `FLS_CMD_ERASE);
  assign o_erase_all = (code == `FLS_CMD_ERASE_ALL);
  assign o_lock_set = (code == `FLS_CMD_LOCK_SET);
  assign o_lock_query = (code == `FLS_CMD_LOCK_QUERY);
  assign o_confirm = (code == `FLS_CMD_CONFIRM);
endmodule // fls_cmd_decode

// ==== src/fls_lock_bits.v ====
// Per-block lock bit store
`timescale 1ns/10ps
`include "fls_consts.vh"
module fls_lock_bits (
  input wire i_clk,
  input wire i_rstn,
  input wire [`FLS_NUM_BLK-1:0] i_clr_mask,
  input wire [`FLS_NUM_BLK-1:0] i_set_mask,
  output wire [`FLS_NUM_BLK-1:0] o_lock_bits
);
  // Stands in for the nonvolatile cells; reset models an erased array
  localparam [`FLS_NUM_BLK-1:0] LOCK_RST = `FLS_LOCK_RESET;
  genvar g;
  generate
    for (g = 0; g < `FLS_NUM_BLK; g = g + 1) begin : g_blk
      reg lock_bit;
      always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          lock_bit <= LOCK_RST[g];
        end else if (i_set_mask[g]) begin
          lock_bit <= 1'b1;
        end else if (i_clr_mask[g]) begin
          lock_bit <= 1'b0;
        end
      end
      assign o_lock_bits[g] = lock_bit;
    end
  endgenerate
endmodule // fls_lock_bits

// ==== src/fls_sequencer.v ====
// Flash command sequencer: lock bits, status byte and error flags
`timescale 1ns/10ps
`include "fls_consts.vh"
module fls_sequencer (
  input wire i_clk,
  input wire i_rstn,
  input wire i_wr,
  input wire i_rd,
  input wire [`FLS_ADDR_W-1:0] i_addr,
  input wire [15:0] i_wdata,
  input wire [15:0] i_array_data,
  input wire i_lock_disable_ctl,
  input wire i_ram_rewrite_mode,
  input wire i_pe_done,
  input wire i_pe_fail,
  output reg o_rd_valid,
  output reg [15:0] o_rdata,
  output reg o_pe_req,
  output reg [1:0] o_pe_op,
  output reg [`FLS_ADDR_W-1:0] o_pe_addr,
  output reg [15:0] o_pe_data,
  output reg [`FLS_NUM_BLK-1:0] o_pe_mask,
  output reg o_seq_ready_flag,
  output reg o_erase_fail_flag,
  output reg o_program_fail_flag,
  output reg o_lock_query_result,
  output reg o_status_mode
);
  // ------------------------------------------------------------
  // States and pending commands
  // ------------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_ARM = 2'd1;
  localparam ST_RUN = 2'd2;
  localparam ST_QRY = 2'd3;

  localparam P_PRG = 3'd0;
  localparam P_ERS = 3'd1;
  localparam P_ERA = 3'd2;
  localparam P_LKS = 3'd3;
  localparam P_LKQ = 3'd4;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [2:0] pend;
  reg [2:0] next_pend;
  reg next_req;
  reg [1:0] next_op;
  reg [`FLS_ADDR_W-1:0] next_pe_addr;
  reg [15:0] next_pe_data;
  reg [`FLS_NUM_BLK-1:0] next_mask;
  reg next_ready;
  reg next_qry;
  reg next_smode;
  reg set_ef;
  reg set_pf;
  reg clr_f;
  reg [`FLS_NUM_BLK-1:0] lock_clr;
  reg [`FLS_NUM_BLK-1:0] lock_set;

  wire is_rda;
  wire is_rds;
  wire is_clr;
  wire is_prg;
  wire is_ers;
  wire is_era;
  wire is_lks;
  wire is_lkq;
  wire is_cnf;
  wire [`FLS_NUM_BLK-1:0] lock_bits;
  wire [`FLS_NUM_BLK-1:0] eff_open;
  wire [`FLS_NUM_BLK-1:0] blk_onehot;
  wire [`FLS_NUM_BLK-1:0] all_mask;
  wire [3:0] blk;
  wire blk_open;
  wire any_fail;
  wire [7:0] status_byte;

  // ------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------
  fls_cmd_decode i_fls_cmd_decode (
    .i_word(i_wdata),
    .o_read_array(is_rda),
    .o_read_status(is_rds),
    .o_clear_status(is_clr),
    .o_program(is_prg),
    .o_erase(is_ers),
    .o_erase_all(is_era),
    .o_lock_set(is_lks),
    .o_lock_query(is_lkq),
    .o_confirm(is_cnf)
  );

  fls_lock_bits i_fls_lock_bits (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_clr_mask(lock_clr),
    .i_set_mask(lock_set),
    .o_lock_bits(lock_bits)
  );

  // ------------------------------------------------------------
  // Lock view
  // ------------------------------------------------------------
  // Disable only masks the view; stored bits are never rewritten by it
  assign eff_open = lock_bits | {`FLS_NUM_BLK{i_lock_disable_ctl}};
  assign blk = i_addr[`FLS_BLK_MSB:`FLS_BLK_LSB];
  assign blk_open = eff_open[blk];
  assign blk_onehot = {{(`FLS_NUM_BLK-1){1'b0}}, 1'b1} << blk;
  // Erase-all never touches block A
  assign all_mask = eff_open & ~({{(`FLS_NUM_BLK-1){1'b0}}, 1'b1} << `FLS_BLK_A);
  assign any_fail = o_erase_fail_flag | o_program_fail_flag;

  assign status_byte = {o_seq_ready_flag, 1'b0, o_erase_fail_flag,
                        o_program_fail_flag, 4'h0};

  // ------------------------------------------------------------
  // Command sequencing
  // ------------------------------------------------------------
  always @* begin
    next_state = state;
    next_pend = pend;
    next_req = 1'b0;
    next_op = o_pe_op;
    next_pe_addr = o_pe_addr;
    next_pe_data = o_pe_data;
    next_mask = o_pe_mask;
    next_qry = o_lock_query_result;
    next_smode = o_status_mode;
    set_ef = 1'b0;
    set_pf = 1'b0;
    clr_f = 1'b0;
    lock_clr = {`FLS_NUM_BLK{1'b0}};
    lock_set = {`FLS_NUM_BLK{1'b0}};
    case (state)
      ST_IDLE: begin
        // Writes reach here only while ready
        if (i_wr) begin
          if (is_rda) begin
            next_smode = 1'b0;
          end else if (is_rds) begin
            next_smode = 1'b1;
          end else if (is_clr) begin
            clr_f = 1'b1;
          end else if (is_lkq) begin
            next_pend = P_LKQ;
            next_state = ST_ARM;
          end else if (!any_fail && (is_prg || is_ers || is_era || is_lks)) begin
            next_state = ST_ARM;
            if (is_prg) begin
              next_pend = P_PRG;
            end else if (is_ers) begin
              next_pend = P_ERS;
            end else if (is_era) begin
              next_pend = P_ERA;
            end else begin
              next_pend = P_LKS;
            end
          end
        end
      end
      ST_ARM: begin
        if (i_wr) begin
          next_state = ST_IDLE;
          if (pend == P_PRG) begin
            if (i_ram_rewrite_mode) begin
              next_smode = 1'b1;
            end
            if (blk_open) begin
              next_req = 1'b1;
              next_op = `FLS_OP_PROGRAM;
              next_pe_addr = i_addr;
              next_pe_data = i_wdata;
              next_mask = blk_onehot;
              next_state = ST_RUN;
            end else begin
              set_pf = 1'b1;
            end
          end else if (is_rda) begin
            next_smode = 1'b0;
          end else if (!is_cnf) begin
            if (pend != P_LKQ) begin
              set_ef = 1'b1;
              set_pf = 1'b1;
            end
          end else if (pend == P_LKQ) begin
            next_qry = lock_bits[blk];
            next_state = ST_QRY;
          end else begin
            if (i_ram_rewrite_mode) begin
              next_smode = 1'b1;
            end
            next_pe_addr = i_addr;
            if (pend == P_ERA) begin
              next_req = 1'b1;
              next_op = `FLS_OP_ERASE_ALL;
              next_mask = all_mask;
              next_state = ST_RUN;
            end else if (pend == P_ERS) begin
              if (blk_open) begin
                next_req = 1'b1;
                next_op = `FLS_OP_ERASE;
                next_mask = blk_onehot;
                next_state = ST_RUN;
              end else begin
                set_ef = 1'b1;
              end
            end else begin
              // Locking an already locked block is harmless
              next_req = 1'b1;
              next_op = `FLS_OP_LOCK_SET;
              next_mask = blk_onehot;
              next_state = ST_RUN;
            end
          end
        end
      end
      ST_RUN: begin
        if (i_pe_done) begin
          next_state = ST_IDLE;
          case (o_pe_op)
            `FLS_OP_PROGRAM: begin
              set_pf = i_pe_fail;
            end
            `FLS_OP_LOCK_SET: begin
              if (i_pe_fail) begin
                set_pf = 1'b1;
              end else begin
                lock_clr = o_pe_mask;
              end
            end
            default: begin
              if (i_pe_fail) begin
                set_ef = 1'b1;
              end else begin
                lock_set = o_pe_mask;
              end
            end
          endcase
        end
      end
      ST_QRY: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_ready = (next_state != ST_RUN) && (next_state != ST_QRY);
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
      pend <= P_PRG;
      o_pe_req <= 1'b0;
      o_pe_op <= `FLS_OP_PROGRAM;
      o_pe_addr <= {`FLS_ADDR_W{1'b0}};
      o_pe_data <= 16'h0000;
      o_pe_mask <= {`FLS_NUM_BLK{1'b0}};
      o_seq_ready_flag <= `FLS_READY_RESET;
      o_erase_fail_flag <= `FLS_FAIL_RESET;
      o_program_fail_flag <= `FLS_FAIL_RESET;
      o_lock_query_result <= 1'b0;
      o_status_mode <= 1'b0;
    end else begin
      state <= next_state;
      pend <= next_pend;
      o_pe_req <= next_req;
      o_pe_op <= next_op;
      o_pe_addr <= next_pe_addr;
      o_pe_data <= next_pe_data;
      o_pe_mask <= next_mask;
      o_seq_ready_flag <= next_ready;
      o_lock_query_result <= next_qry;
      o_status_mode <= next_smode;
      // A hardware set wins over a clear in the same cycle
      o_erase_fail_flag <= (o_erase_fail_flag & ~clr_f) | set_ef;
      o_program_fail_flag <= (o_program_fail_flag & ~clr_f) | set_pf;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Status comes from the flags before this edge, so a read in the
  // cycle a flag changes still shows the old value
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd_valid <= 1'b0;
      o_rdata <= 16'h0000;
    end else begin
      o_rd_valid <= i_rd;
      if (i_rd) begin
        if (o_status_mode) begin
          o_rdata <= {8'h00, status_byte};
        end else begin
          o_rdata <= i_array_data;
        end
      end
    end
  end
endmodule // fls_sequencer

// ==== testbench/fls_sequencer_properties.sv ====
// Port-level assertions for the flash command sequencer
`timescale 1ns/10ps
module fls_sequencer_properties (
  input wire i_clk,
  input wire i_rstn,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] i_wdata,
  input wire [15:0] i_array_data,
  input wire i_pe_done,
  input wire o_rd_valid,
  input wire [15:0] o_rdata,
  input wire o_pe_req,
  input wire o_seq_ready_flag,
  input wire o_erase_fail_flag,
  input wire o_program_fail_flag,
  input wire o_status_mode
);
  // ----------------------------------------
  // Pending first cycle, so a second cycle is told apart from a new command
  // ----------------------------------------
  reg [7:0] first;
  wire [7:0] code = i_wdata[7:0];
  wire fail = o_erase_fail_flag | o_program_fail_flag;
  wire two = code == 8'h40 || code == 8'h20 || code == 8'ha7 || code == 8'h77;
  wire erase_kind = first == 8'h20 || first == 8'ha7 || first == 8'h77;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      first <= 8'h00;
    end else if (i_wr && o_seq_ready_flag) begin
      first <= (first == 8'h00 && (code == 8'h71 || (two && !fail))) ? code : 8'h00;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  req_drops_ready_a: assert property (o_pe_req |-> !o_seq_ready_flag)
    else $error("ready high at engine start");
  query_busy_one_a: assert property ($fell(o_seq_ready_flag) && !o_pe_req |=> o_seq_ready_flag)
    else $error("lock query busy too long");
  done_gives_ready_a: assert property (!o_seq_ready_flag && !o_pe_req && i_pe_done |=> o_seq_ready_flag)
    else $error("ready missing after done");
  busy_holds_a: assert property (o_pe_req && !i_pe_done |=> !o_seq_ready_flag)
    else $error("busy dropped early");
  status_byte_a: assert property (o_rd_valid && $past(o_status_mode) |-> o_rdata == {8'h00,
    $past(o_seq_ready_flag), 1'b0, $past(o_erase_fail_flag), $past(o_program_fail_flag), 4'h0})
    else $error("status byte wrong");
  array_read_a: assert property (o_rd_valid && !$past(o_status_mode) |-> o_rdata == $past(i_array_data))
    else $error("array data wrong");
  read_latency_a: assert property (i_rd |=> o_rd_valid)
    else $error("read answer late");
  clear_status_a: assert property (i_wr && o_seq_ready_flag && first == 8'h00 && code == 8'h50
    |=> !o_erase_fail_flag && !o_program_fail_flag)
    else $error("flags not cleared");
  seq_error_a: assert property (i_wr && erase_kind && code != 8'hd0 && code != 8'hff
    |=> o_erase_fail_flag && o_program_fail_flag)
    else $error("sequence error missed");
  cancel_ff_a: assert property (i_wr && erase_kind && code == 8'hff
    |=> o_seq_ready_flag && !o_pe_req && !o_status_mode)
    else $error("cancel not honoured");
  fail_blocks_a: assert property (o_pe_req |-> !$past(o_erase_fail_flag) && !$past(o_program_fail_flag))
    else $error("operation started with error set");
endmodule // fls_sequencer_properties
bind fls_sequencer fls_sequencer_properties i_fls_sequencer_properties (.i_clk, .i_rstn, .i_wr,
  .i_rd, .i_wdata, .i_array_data, .i_pe_done, .o_rd_valid, .o_rdata, .o_pe_req,
  .o_seq_ready_flag, .o_erase_fail_flag, .o_program_fail_flag, .o_status_mode);

// ==== testbench/fls_pe_engine_model.sv ====
// Behavioural program and erase engine facing the sequencer
`timescale 1ns/10ps
module fls_pe_engine_model (
  input wire i_clk,
  input wire i_rstn,
  input wire i_pe_req,
  input wire [3:0] i_delay,
  input wire i_fail_en,
  output reg o_pe_done,
  output wire o_pe_fail
);
  reg [3:0] cnt;
  reg fail_q;
  reg noise;
  // Fail means nothing beside done, so it wanders there
  assign o_pe_fail = o_pe_done ? fail_q : noise;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 4'h0;
      o_pe_done <= 1'b0;
      fail_q <= 1'b0;
      noise <= 1'b0;
    end else begin
      noise <= ~noise;
      o_pe_done <= cnt == 4'h1;
      if (i_pe_req) begin
        cnt <= i_delay;
        fail_q <= i_fail_en;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule // fls_pe_engine_model

// ==== testbench/fls_sequencer_tb.sv ====
// Self-checking bench for the flash command sequencer
`timescale 1ns/10ps
module fls_sequencer_tb;
  typedef struct {logic [15:0] c1; logic [15:0] c2; logic [19:0] a; logic dis; logic fe;
    logic [7:0] st; logic [1:0] q;} fls_row_t;
  reg i_clk = 1'b0;
  reg i_rstn = 1'b0;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg [19:0] i_addr = 20'h00000;
  reg [15:0] i_wdata = 16'h0000;
  reg [15:0] i_array_data = 16'h0000;
  reg i_lock_disable_ctl = 1'b0;
  reg i_ram_rewrite_mode = 1'b1;
  reg [3:0] dly = 4'h3;
  reg fail_en = 1'b0;
  wire pe_done, pe_fail, o_rd_valid, o_pe_req, o_seq_ready_flag, o_erase_fail_flag;
  wire o_program_fail_flag, o_lock_query_result, o_status_mode;
  wire [15:0] o_rdata;
  wire [1:0] pe_op;
  wire [19:0] pe_addr;
  wire [15:0] pe_data, pe_mask;
  int num_errors = 0;
  int n_compared = 0;
  fls_row_t rows [11];
  always #2 i_clk = ~i_clk;
  fls_sequencer i_fls_sequencer (.i_clk, .i_rstn, .i_wr, .i_rd, .i_addr, .i_wdata,
    .i_array_data, .i_lock_disable_ctl, .i_ram_rewrite_mode, .i_pe_done(pe_done),
    .i_pe_fail(pe_fail), .o_rd_valid, .o_rdata, .o_pe_req, .o_pe_op(pe_op),
    .o_pe_addr(pe_addr), .o_pe_data(pe_data), .o_pe_mask(pe_mask), .o_seq_ready_flag,
    .o_erase_fail_flag, .o_program_fail_flag,
    .o_lock_query_result, .o_status_mode);
  fls_pe_engine_model i_fls_pe_engine_model (.i_clk, .i_rstn, .i_pe_req(o_pe_req),
    .i_delay(dly), .i_fail_en(fail_en), .o_pe_done(pe_done), .o_pe_fail(pe_fail));
  task check(input [15:0] seen, input [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task wr(input [15:0] d, input [19:0] a);
    tick(1);
    i_wr = 1'b1;
    i_wdata = d;
    i_addr = a;
    tick(1);
    i_wr = 1'b0;
  endtask
  task wait_ready;
    int k;
    k = 0;
    while (o_seq_ready_flag !== 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
    if (o_seq_ready_flag !== 1'b1) begin
      num_errors++;
      print_verdict;
    end
  endtask
  task rd_raw;
    i_rd = 1'b1;
    i_array_data = 16'h5a3c;
    tick(1);
    i_rd = 1'b0;
    check(o_rd_valid, 16'h0001, "read valid");
  endtask
  task rd_status(input [7:0] st);
    wr(16'h3370, 20'h00000);
    rd_raw;
    check(o_rdata, {8'h00, st}, "status");
  endtask
  task query(input [19:0] a, input [1:0] q);
    wr(16'h0071, a);
    wr(16'hd0d0, a);
    wait_ready;
    if (q != 2'h2) check(o_lock_query_result, q[0], "lock query");
  endtask
  task rst;
    i_rstn = 1'b0;
    tick(3);
    check({o_seq_ready_flag, o_erase_fail_flag, o_program_fail_flag, o_status_mode}, 4'h8, "reset");
    i_rstn = 1'b1;
  endtask
  initial begin
    rows[0] = '{16'h0071, 16'h00d0, 20'h03ffe, 0, 0, 8'h80, 2'h1};
    rows[1] = '{16'hab77, 16'h00d0, 20'h03ffe, 0, 0, 8'h80, 2'h0};
    rows[2] = '{16'h0040, 16'h1234, 20'h03ffe, 0, 0, 8'h90, 2'h0};
    rows[3] = '{16'h0020, 16'h00d0, 20'h03ffe, 0, 0, 8'ha0, 2'h0};
    rows[4] = '{16'h0040, 16'h1234, 20'h03ffe, 1, 0, 8'h80, 2'h0};
    rows[5] = '{16'h0020, 16'h00d0, 20'h03ffe, 1, 0, 8'h80, 2'h1};
    rows[6] = '{16'h0077, 16'h00d0, 20'h05ffe, 0, 1, 8'h90, 2'h1};
    rows[7] = '{16'h0020, 16'h00d0, 20'h06ffe, 0, 1, 8'ha0, 2'h1};
    rows[8] = '{16'h0020, 16'h0055, 20'h06ffe, 0, 0, 8'hb0, 2'h1};
    rows[9] = '{16'h0077, 16'h00d0, 20'h0fffe, 0, 0, 8'h80, 2'h0};
    rows[10] = '{16'h00a7, 16'h00d0, 20'h0fffe, 0, 0, 8'h80, 2'h0};
    rst;
    for (int r = 0; r < 11; r++) begin
      i_lock_disable_ctl = rows[r].dis;
      fail_en = rows[r].fe;
      wr(16'h0050, 20'h00000);
      wr(rows[r].c1, rows[r].a);
      wr(rows[r].c2, rows[r].a);
      wait_ready;
      rd_status(rows[r].st);
      query(rows[r].a, rows[r].q);
      wr(16'h00ff, 20'h00000);
    end
    i_lock_disable_ctl = 1'b0;
    fail_en = 1'b0;
    dly = 4'hf;
    wr(16'h0020, 20'h01ffe);
    wr(16'h00d0, 20'h01ffe);
    wr(16'h0077, 20'h02ffe);
    wr(16'h00d0, 20'h02ffe);
    check(o_seq_ready_flag, 16'h0000, "busy");
    check(pe_op, 16'h0001, "erase op");
    check(pe_mask, 16'h0002, "erase mask");
    check(pe_addr[15:0], 16'h1ffe, "erase addr");
    wait_ready;
    dly = 4'h3;
    rd_raw;
    check(o_rdata, 16'h0080, "status mode read");
    query(20'h02ffe, 2'h1);
    wr(16'h0040, 20'h04ffe);
    wr(16'hbeef, 20'h04ffe);
    check(pe_op, 16'h0000, "program op");
    check(pe_data, 16'hbeef, "program data");
    check(pe_mask, 16'h0010, "program mask");
    wait_ready;
    wr(16'h00ff, 20'h00000);
    rd_raw;
    check(o_rdata, 16'h5a3c, "array read");
    wr(16'h0020, 20'h06ffe);
    wr(16'h0055, 20'h06ffe);
    wr(16'h0077, 20'h01ffe);
    wr(16'h00d0, 20'h01ffe);
    tick(1);
    check(o_seq_ready_flag, 16'h0001, "refused");
    query(20'h01ffe, 2'h1);
    wr(16'h0050, 20'h00000);
    check({o_erase_fail_flag, o_program_fail_flag}, 16'h0000, "clear");
    wr(16'h0070, 20'h00000);
    wr(16'h0020, 20'h01ffe);
    wr(16'h00ff, 20'h01ffe);
    check(o_status_mode, 16'h0000, "cancel");
    rd_status(8'h80);
    wr(16'h0020, 20'h06ffe);
    wr(16'h0055, 20'h06ffe);
    rst;
    rd_status(8'h80);
    print_verdict;
  end
endmodule // fls_sequencer_tb
